// File: core/fsr_core.sv
// Serial flash command core with security register store and staging FIFO
`timescale 1ns/10ps
`include "fsr_params.svh"

module fsr_fifo #(
  parameter int W  = `FSR_FIFO_WIDTH,
  parameter int D  = `FSR_FIFO_DEPTH,
  parameter int AW = $clog2(D)
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         flush,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem [0:D-1];
  logic [AW:0]  wr_ptr_ff;
  logic [AW:0]  rd_ptr_ff;

  assign in_ready  = (wr_ptr_ff[AW] == rd_ptr_ff[AW]) ||
                     (wr_ptr_ff[AW-1:0] != rd_ptr_ff[AW-1:0]);
  assign out_valid = wr_ptr_ff != rd_ptr_ff;
  assign out_data  = mem[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end
endmodule

module fsr_core #(
  parameter int SECPROG_CYCLES = 12500,
  parameter int PROG_CYCLES    = 12500,
  parameter int ERASE_CYCLES   = 100000,
  parameter int OTHER_CYCLES   = 50000
) (
  // Clock and reset
  input  wire logic     REF_CLK,
  input  wire logic     RESET_N,
  // Serial pins
  input  wire logic     SPI_CS_N,
  input  wire logic     SPI_SCLK,
  input  wire logic     SPI_SI,
  output logic          SPI_SO,
  output logic          SPI_SO_OE,
  // Nonvolatile lock bits
  input  wire logic [2:0] OTP_LOCK_BITS,
  // Status
  output logic          OP_IN_PROGRESS_FLAG,
  output logic          WRITE_ENABLE_LATCH,
  output logic [1:0]    HALTED_OP_FLAGS,
  output logic          SLEEP_ACTIVE,
  output logic          RESET_BUSY,
  output logic          SETTINGS_CLEAR,
  output fsr_pkg::fsr_op_t OP_KIND
);
  import fsr_pkg::*;

  localparam int SUS_A    = `FSR_SUS_CYC;
  localparam int RESUME_A = `FSR_RESUME_CYC;

  logic [2:0]  cs_sync_ff, sck_sync_ff, si_sync_ff;
  logic [7:0]  sh_ff, op_ff, out_sh_ff;
  logic [2:0]  bit_cnt_ff, byte_cnt_ff;
  logic [23:0] addr_ff;
  logic [9:0]  rd_addr_ff;
  logic        out_en_ff, so_ff;
  fsr_state_t  state_ff;
  fsr_op_t     kind_ff, save_kind_ff;
  logic [23:0] op_cnt_ff, hold_cnt_ff;
  logic [15:0] wait_cnt_ff, dp_cnt_ff, wake_cnt_ff;
  logic [1:0]  halt_ff;
  logic        wel_ff, arm_ff, dpd_ff, clr_ff;
  logic [2:0]  lock_ff;
  logic [11:0] prog_idx_ff;
  logic [7:0]  mem [0:`FSR_MEM_BYTES-1];
  logic [`FSR_MEM_BYTES-1:0] prog_seen_ff;

  logic        cs_act, sck_rise, sck_fall, byte_done, frame_end;
  logic [7:0]  nb;
  logic        sreg_ok, locked, asleep, cmd_gate, op_in_progress_flag;
  logic [1:0]  sel_idx;
  logic        aligned, exact1;
  logic        is_prog, is_sprog, is_erase, is_other;
  logic        start_any, halt_acc, cont_acc, sleep_acc, wake_acc;
  logic        rsten_acc, rst_acc, write_enable_cmd_acc, wrdi_acc, op_done;
  fsr_op_t     new_kind;
  logic        push_ok, fifo_ready, fifo_valid, pop;
  logic [7:0]  fifo_data;

  // Pins cross into REF_CLK through two flops before use
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      cs_sync_ff  <= 3'h7;
      sck_sync_ff <= 3'h0;
      si_sync_ff  <= 3'h0;
    end else begin
      cs_sync_ff  <= {cs_sync_ff[1:0], SPI_CS_N};
      sck_sync_ff <= {sck_sync_ff[1:0], SPI_SCLK};
      si_sync_ff  <= {si_sync_ff[1:0], SPI_SI};
    end
  end

  assign cs_act    = !cs_sync_ff[1];
  assign sck_rise  = cs_act && sck_sync_ff[1] && !sck_sync_ff[2];
  assign sck_fall  = cs_act && !sck_sync_ff[1] && sck_sync_ff[2];
  assign frame_end = cs_sync_ff[1] && !cs_sync_ff[2];
  assign byte_done = sck_rise && (bit_cnt_ff == 3'h7);
  assign nb        = {sh_ff[6:0], si_sync_ff[1]};

  assign sreg_ok = (addr_ff[23:16] == 8'h00) &&
                   (addr_ff[15:12] >= 4'h1) &&
                   (addr_ff[15:12] <= 4'h3) &&
                   (addr_ff[11:10] == 2'h0);
  assign sel_idx = addr_ff[13:12] - 2'h1;
  assign locked  = lock_ff[sel_idx];
  assign asleep  = dpd_ff || (dp_cnt_ff != 16'h0);
  assign op_in_progress_flag     = (state_ff == ST_RUN) || (state_ff == ST_HALTING) ||
                   (state_ff == ST_NESTED);
  // Recovery and wake windows refuse everything
  assign cmd_gate = (state_ff != ST_RESET) && (wake_cnt_ff == 16'h0) &&
                    (!asleep || op_ff == `FSR_OP_WAKE ||
                     op_ff == `FSR_OP_RSTEN ||
                     op_ff == `FSR_OP_RST);

  // Frame shifter, read pointer and output shifter
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N || !cs_act) begin
      sh_ff       <= 8'h00;
      bit_cnt_ff  <= 3'h0;
      byte_cnt_ff <= 3'h0;
      out_en_ff   <= 1'b0;
      if (!RESET_N) begin
        op_ff      <= 8'h00;
        addr_ff    <= 24'h000000;
        rd_addr_ff <= 10'h000;
        out_sh_ff  <= 8'h00;
        so_ff      <= 1'b0;
      end
    end else begin
      if (sck_rise) begin
        sh_ff      <= nb;
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end
      if (byte_done) begin
        if (byte_cnt_ff != 3'h7) begin
          byte_cnt_ff <= byte_cnt_ff + 3'h1;
        end
        if (byte_cnt_ff == 3'h0) begin
          op_ff <= nb;
        end else if (byte_cnt_ff <= 3'h3) begin
          addr_ff <= {addr_ff[15:0], nb};
        end
        if (byte_cnt_ff == 3'h3) begin
          rd_addr_ff <= {addr_ff[1:0], nb};
        end
        // Dummy byte done: first data byte goes out on next fall
        if (op_ff == `FSR_OP_SREAD && byte_cnt_ff >= 3'h4 &&
            cmd_gate && sreg_ok) begin
          out_sh_ff  <= prog_seen_ff[{sel_idx, rd_addr_ff}] ?
                        mem[{sel_idx, rd_addr_ff}] : 8'hFF;
          rd_addr_ff <= rd_addr_ff + 10'h001;
          out_en_ff  <= 1'b1;
        end
        if (op_ff == `FSR_OP_WAKE && byte_cnt_ff >= 3'h3 &&
            cmd_gate && !op_in_progress_flag) begin
          out_sh_ff <= `FSR_DEVICE_ID;
          out_en_ff <= 1'b1;
        end
      end
      if (sck_fall && out_en_ff) begin
        so_ff     <= out_sh_ff[7];
        out_sh_ff <= {out_sh_ff[6:0], 1'b0};
      end
    end
  end

  assign SPI_SO    = so_ff;
  assign SPI_SO_OE = out_en_ff;

  // Frame decode, judged at select rise
  assign aligned = bit_cnt_ff == 3'h0;
  assign exact1  = aligned && (byte_cnt_ff == 3'h1);
  assign is_prog = (op_ff == `FSR_OP_PP || op_ff == `FSR_OP_QPP) &&
                   byte_cnt_ff >= 3'h5;
  assign is_sprog = op_ff == `FSR_OP_SPROG && byte_cnt_ff >= 3'h5 &&
                    sreg_ok && !locked;
  assign is_erase = (op_ff == `FSR_OP_SE || op_ff == `FSR_OP_BE32 ||
                     op_ff == `FSR_OP_BE64) && byte_cnt_ff == 3'h4;
  assign is_other = ((op_ff == `FSR_OP_CE1 || op_ff == `FSR_OP_CE2) &&
                     byte_cnt_ff == 3'h1) ||
                    (op_ff == `FSR_OP_SERASE && byte_cnt_ff == 3'h4 &&
                     sreg_ok && !locked) ||
                    ((op_ff == `FSR_OP_WRSR1 || op_ff == `FSR_OP_WRSR2 ||
                      op_ff == `FSR_OP_WRSR3) && byte_cnt_ff >= 3'h2);
  // Halted erase lets only programs through; halted program nothing
  assign start_any = frame_end && aligned && cmd_gate && wel_ff &&
                     ((state_ff == ST_IDLE &&
                       (is_prog || is_sprog || is_erase || is_other)) ||
                      (state_ff == ST_HALTED && halt_ff[0] &&
                       (is_prog || is_sprog)));
  assign new_kind = is_sprog ? OP_SECPROG :
                    is_prog  ? OP_PROG :
                    is_erase ? OP_ERASE : OP_OTHER;
  assign halt_acc = frame_end && exact1 && op_ff == `FSR_OP_HALT &&
                    cmd_gate && state_ff == ST_RUN &&
                    (kind_ff == OP_PROG || kind_ff == OP_ERASE);
  assign cont_acc = frame_end && exact1 && op_ff == `FSR_OP_CONT &&
                    cmd_gate && state_ff == ST_HALTED;
  assign sleep_acc = frame_end && exact1 && op_ff == `FSR_OP_SLEEP &&
                     cmd_gate && !asleep && !op_in_progress_flag &&
                     state_ff != ST_RESUMING;
  assign wake_acc = frame_end && aligned && op_ff == `FSR_OP_WAKE &&
                    byte_cnt_ff != 3'h0 && cmd_gate && asleep &&
                    !op_in_progress_flag;
  assign rsten_acc = frame_end && exact1 && op_ff == `FSR_OP_RSTEN &&
                     cmd_gate;
  assign rst_acc = frame_end && exact1 && op_ff == `FSR_OP_RST &&
                   arm_ff && cmd_gate;
  assign write_enable_cmd_acc = frame_end && exact1 && op_ff == `FSR_OP_WRITE_ENABLE_CMD &&
                    cmd_gate;
  assign wrdi_acc = frame_end && exact1 && op_ff == `FSR_OP_WRDI &&
                    cmd_gate;
  assign op_done = (op_cnt_ff <= 24'h000001) &&
                   !(kind_ff == OP_SECPROG && fifo_valid);

  function automatic logic [23:0] op_len(input fsr_op_t k);
    case (k)
      OP_SECPROG: op_len = SECPROG_CYCLES[23:0];
      OP_PROG:    op_len = PROG_CYCLES[23:0];
      OP_ERASE:   op_len = ERASE_CYCLES[23:0];
      default:    op_len = OTHER_CYCLES[23:0];
    endcase
  endfunction

  // Operation sequencer
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      state_ff     <= ST_IDLE;
      kind_ff      <= OP_NONE;
      save_kind_ff <= OP_NONE;
      op_cnt_ff    <= 24'h000000;
      hold_cnt_ff  <= 24'h000000;
      wait_cnt_ff  <= 16'h0000;
    end else if (rst_acc) begin
      state_ff    <= ST_RESET;
      kind_ff     <= OP_NONE;
      op_cnt_ff   <= 24'h000000;
      wait_cnt_ff <= 16'(`FSR_RST_CYC);
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start_any) begin
            state_ff  <= ST_RUN;
            kind_ff   <= new_kind;
            op_cnt_ff <= op_len(new_kind);
          end
        end
        ST_RUN: begin
          if (halt_acc) begin
            state_ff    <= ST_HALTING;
            wait_cnt_ff <= 16'(`FSR_SUS_CYC);
          end else if (op_done) begin
            state_ff <= ST_IDLE;
            kind_ff  <= OP_NONE;
          end else if (op_cnt_ff > 24'h000001) begin
            op_cnt_ff <= op_cnt_ff - 24'h000001;
          end
        end
        ST_HALTING: begin
          if (wait_cnt_ff <= 16'h0001) begin
            state_ff <= ST_HALTED;
          end else begin
            wait_cnt_ff <= wait_cnt_ff - 16'h0001;
          end
        end
        ST_HALTED: begin
          if (cont_acc) begin
            state_ff    <= ST_RESUMING;
            wait_cnt_ff <= 16'(`FSR_RESUME_CYC);
          end else if (start_any) begin
            state_ff     <= ST_NESTED;
            save_kind_ff <= kind_ff;
            hold_cnt_ff  <= op_cnt_ff;
            kind_ff      <= new_kind;
            op_cnt_ff    <= op_len(new_kind);
          end
        end
        ST_NESTED: begin
          if (op_done) begin
            state_ff  <= ST_HALTED;
            kind_ff   <= save_kind_ff;
            op_cnt_ff <= hold_cnt_ff;
          end else if (op_cnt_ff > 24'h000001) begin
            op_cnt_ff <= op_cnt_ff - 24'h000001;
          end
        end
        ST_RESUMING, ST_RESET: begin
          if (wait_cnt_ff <= 16'h0001) begin
            state_ff <= (state_ff == ST_RESET) ? ST_IDLE : ST_RUN;
          end else begin
            wait_cnt_ff <= wait_cnt_ff - 16'h0001;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Halted flags, write enable latch, reset arming
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N || rst_acc) begin
      halt_ff <= 2'h0;
      wel_ff  <= 1'b0;
      arm_ff  <= 1'b0;
    end else begin
      if (halt_acc) begin
        halt_ff <= (kind_ff == OP_ERASE) ? 2'h1 : 2'h2;
      end else if (cont_acc) begin
        halt_ff <= 2'h0;
      end
      if (start_any || wrdi_acc) begin
        wel_ff <= 1'b0;
      end else if (write_enable_cmd_acc) begin
        wel_ff <= 1'b1;
      end
      if (frame_end) begin
        arm_ff <= rsten_acc;
      end
    end
  end

  // Sleep entry and wake timing
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N || rst_acc) begin
      dpd_ff      <= 1'b0;
      dp_cnt_ff   <= 16'h0000;
      wake_cnt_ff <= 16'h0000;
    end else if (wake_acc) begin
      dpd_ff      <= 1'b0;
      dp_cnt_ff   <= 16'h0000;
      wake_cnt_ff <= 16'(`FSR_RES1_CYC);
    end else begin
      if (sleep_acc) begin
        dp_cnt_ff <= 16'(`FSR_DP_CYC);
      end else if (dp_cnt_ff != 16'h0000) begin
        dp_cnt_ff <= dp_cnt_ff - 16'h0001;
        if (dp_cnt_ff == 16'h0001) begin
          dpd_ff <= 1'b1;
        end
      end
      if (wake_cnt_ff != 16'h0000) begin
        wake_cnt_ff <= wake_cnt_ff - 16'h0001;
      end
    end
  end

  // Lock bits only ever accumulate until power-on
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      lock_ff <= 3'h0;
      clr_ff  <= 1'b0;
    end else begin
      lock_ff <= lock_ff | OTP_LOCK_BITS;
      clr_ff  <= rst_acc;
    end
  end

  // Data bytes of a security program frame stage here; extra bytes beyond
  // the depth are dropped because the serial host cannot be stalled
  assign push_ok = byte_done && op_ff == `FSR_OP_SPROG &&
                   byte_cnt_ff >= 3'h4 && cmd_gate &&
                   (state_ff == ST_IDLE || state_ff == ST_HALTED);
  assign pop = fifo_valid && kind_ff == OP_SECPROG &&
               (state_ff == ST_RUN || state_ff == ST_NESTED);

  fsr_fifo #(
    .W (`FSR_FIFO_WIDTH),
    .D (`FSR_FIFO_DEPTH)
  ) u_fifo (
    .clk       (REF_CLK),
    .rst_n     (RESET_N),
    .flush     (rst_acc || (frame_end && op_ff == `FSR_OP_SPROG &&
                            !start_any)),
    .in_valid  (push_ok),
    .in_ready  (fifo_ready),
    .in_data   (nb),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  // Programming can only clear bits; the byte pointer wraps in a page
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      prog_idx_ff <= 12'h000;
    end else if (start_any && is_sprog) begin
      prog_idx_ff <= {sel_idx, addr_ff[9:0]};
    end else if (pop) begin
      prog_idx_ff <= {prog_idx_ff[11:8], prog_idx_ff[7:0] + 8'h01};
    end
  end

  // Store has no reset; untouched bytes read as erased instead of X
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      prog_seen_ff <= '0;
    end else if (pop) begin
      prog_seen_ff[prog_idx_ff] <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (pop) begin
      mem[prog_idx_ff] <= prog_seen_ff[prog_idx_ff] ?
                          (mem[prog_idx_ff] & fifo_data) : fifo_data;
    end
  end

  assign OP_IN_PROGRESS_FLAG = op_in_progress_flag;
  assign WRITE_ENABLE_LATCH  = wel_ff;
  assign HALTED_OP_FLAGS     = halt_ff;
  assign SLEEP_ACTIVE        = dpd_ff;
  assign RESET_BUSY          = state_ff == ST_RESET;
  assign SETTINGS_CLEAR      = clr_ff;
  assign OP_KIND             = kind_ff;

  wel_gate_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    start_any |-> wel_ff ##1 !wel_ff)
    else $error("cycle started without write enable");
  lock_gate_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (start_any && op_ff == `FSR_OP_SPROG) |-> !locked && sreg_ok)
    else $error("locked or bad security address programmed");
  halt_flag_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    halt_acc |=> (halt_ff != 2'h0) && op_in_progress_flag ##[0:SUS_A] !op_in_progress_flag)
    else $error("halt did not settle in time");
  cont_busy_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    cont_acc |=> (halt_ff == 2'h0) ##[1:RESUME_A] op_in_progress_flag)
    else $error("continue did not restore busy");
  halt_accept_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    halt_acc |-> $past(halt_ff) == 2'h0 && state_ff == ST_RUN)
    else $error("halt accepted in wrong state");
  rst_refuse_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (state_ff == ST_RESET) |-> !start_any && !write_enable_cmd_acc && !sleep_acc)
    else $error("command accepted during reset recovery");
  sleep_ignore_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    dpd_ff |-> !start_any && !halt_acc && !out_en_ff ||
               op_ff == `FSR_OP_WAKE)
    else $error("command accepted while asleep");
  sleep_busy_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (frame_end && op_in_progress_flag) |=> dp_cnt_ff == $past(dp_cnt_ff) ||
                           dp_cnt_ff == $past(dp_cnt_ff) - 16'h0001)
    else $error("sleep accepted during a cycle");
  halted_prog_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (state_ff == ST_HALTED && halt_ff[1]) |-> !start_any)
    else $error("command accepted in halted program");
  read_wrap_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (cs_act && $past(cs_act) && rd_addr_ff == 10'h000 &&
     $past(rd_addr_ff) != 10'h000 && $past(byte_cnt_ff) >= 3'h4)
    |-> $past(rd_addr_ff) == 10'h3FF)
    else $error("read pointer left its register");
endmodule

// File: core/fsr_params.svh
// Opcodes, identifier, sizes and timing counts for the flash command core
// Summary of operation
// - Program frame: opcode, address, data, one select
// - Security program needs write enable latch set
// - Select rise starts timed program, busy shown
// - Locked security register ignores program permanently
// - Address: zero top, select 1-3, byte offset
// - Read takes address plus dummy, outputs falling
// - Read address increments, wraps inside register
// - Reset needs enable frame then reset frame
// - Reset aborts work, restores power-on defaults
// - No command accepted during reset recovery
// - Halt accepted only during running program/erase
// - Halt sets halted flag, busy drops later
// - Program halted: block writes, erases, programs
// - Erase halted: block writes, erases; programs allowed
// - Continue accepted only when halted and idle
// - Continue clears halt, busy returns within 200ns
// - Sleep needs select rise after eighth bit
// - Asleep: only wake command or reset accepted
// - Sleep refused while a cycle is running
// - Wake command outputs identifier after three dummies
// - Wake command ignored while busy
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH

`define FSR_OP_SPROG  8'h42
`define FSR_OP_SREAD  8'h48
`define FSR_OP_SERASE 8'h44
`define FSR_OP_RSTEN  8'h66
`define FSR_OP_RST    8'h99
`define FSR_OP_HALT   8'h75
`define FSR_OP_CONT   8'h7A
`define FSR_OP_SLEEP  8'hB9
`define FSR_OP_WAKE   8'hAB
`define FSR_OP_WRITE_ENABLE_CMD   8'h06
`define FSR_OP_WRDI   8'h04
`define FSR_OP_PP     8'h02
`define FSR_OP_QPP    8'h32
`define FSR_OP_SE     8'h20
`define FSR_OP_BE32   8'h52
`define FSR_OP_BE64   8'hD8
`define FSR_OP_CE1    8'h60
`define FSR_OP_CE2    8'hC7
`define FSR_OP_WRSR1  8'h01
`define FSR_OP_WRSR2  8'h31
`define FSR_OP_WRSR3  8'h11

// Arbitrary identifier value
`define FSR_DEVICE_ID 8'h5A

`define FSR_FIFO_WIDTH 8
`define FSR_FIFO_DEPTH 16
`define FSR_MEM_BYTES  3072

`define FSR_CLK_NS    40
`define FSR_SUS_NS    20000
`define FSR_SUS_CYC   ((`FSR_SUS_NS) / (`FSR_CLK_NS))
`define FSR_RESUME_NS 200
`define FSR_RESUME_CYC ((`FSR_RESUME_NS) / (`FSR_CLK_NS))
`define FSR_RST_NS    30000
`define FSR_RST_CYC   ((`FSR_RST_NS + `FSR_CLK_NS - 1) / (`FSR_CLK_NS))
`define FSR_DP_NS     3000
`define FSR_DP_CYC    ((`FSR_DP_NS + `FSR_CLK_NS - 1) / (`FSR_CLK_NS))
`define FSR_RES1_NS   20000
`define FSR_RES1_CYC  ((`FSR_RES1_NS + `FSR_CLK_NS - 1) / (`FSR_CLK_NS))

`endif

// File: core/fsr_pkg.sv
// Types shared by the flash command core
package fsr_pkg;
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_RUN      = 3'b001,
    ST_HALTING  = 3'b010,
    ST_HALTED   = 3'b011,
    ST_NESTED   = 3'b100,
    ST_RESUMING = 3'b101,
    ST_RESET    = 3'b110
  } fsr_state_t;

  typedef enum logic [2:0] {
    OP_NONE    = 3'b000,
    OP_SECPROG = 3'b001,
    OP_PROG    = 3'b010,
    OP_ERASE   = 3'b011,
    OP_OTHER   = 3'b100
  } fsr_op_t;
endpackage

// File: dv/flash_secreg_suspend_power_cmds_test.sv
// Self-checking bench for the flash command core
`timescale 1ns/10ps
`include "fsr_params.svh"
module flash_secreg_suspend_power_cmds_test;
  import fsr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] lock = 3'b000;
  logic cs_n, sclk, si, so, so_oe, rx_stb, busy, write_enable_latch, sleep, rbusy, sclr;
  logic [7:0] rx_byte, d0, d1;
  logic [1:0] halt;
  fsr_op_t kind;
  int err_total, checks, clr_n;
  logic [7:0] exp_q [$];
  logic [63:0] hop [2] = '{64'hD8000000, 64'h0200000000};
  int hn [2] = '{4, 5};

  always #20 clk = ~clk;

  // Undriven output shows the inverse, so a late enable is caught
  fsr_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si),
    .so(so_oe ? so : ~so),
    .rx_stb(rx_stb), .rx_byte(rx_byte));

  // Long cycles shortened so halts land mid-operation
  fsr_core #(.SECPROG_CYCLES(40), .PROG_CYCLES(3000),
    .ERASE_CYCLES(3000)) dut_u (
    .REF_CLK(clk), .RESET_N(rst_n), .SPI_CS_N(cs_n), .SPI_SCLK(sclk),
    .SPI_SI(si), .SPI_SO(so), .SPI_SO_OE(so_oe), .OTP_LOCK_BITS(lock),
    .OP_IN_PROGRESS_FLAG(busy), .WRITE_ENABLE_LATCH(write_enable_latch),
    .HALTED_OP_FLAGS(halt), .SLEEP_ACTIVE(sleep), .RESET_BUSY(rbusy),
    .SETTINGS_CLEAR(sclr), .OP_KIND(kind));

  task automatic chk(input string nm, input logic [7:0] s,
                     input logic [7:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmd(input int n, input logic [63:0] v, input int h);
    for (int i = 0; i < n; i++)
      host.tx[i] = v[8*(n-1-i) +: 8];
    host.xfer(n, h);
  endtask

  task automatic wait_busy(input int lim, input logic want);
    int k;
    k = 0;
    while (busy !== want) begin
      host.tick(1);
      k++;
      if (k > lim) begin
        err_total++;
        $display("wrong value busy expected %b seen %b", want, busy);
        wrap_up();
      end
    end
    #1;
  endtask

  always @(posedge clk)
    if (sclr === 1'b1)
      clr_n++;

  // Oldest note matches each byte the host receives
  always @(posedge clk)
    if (rx_stb === 1'b1) begin
      if (exp_q.size() == 0)
        chk("rx queue", 8'h00, 8'hFF);
      else
        chk("rx byte", rx_byte, exp_q.pop_front());
    end

  initial begin
    void'($urandom(64918));
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    host.tick(20);
    rst_n = 1'b1;
    host.tick(4);
    chk("idle state", {busy, write_enable_latch, halt, sleep, kind}, 8'h00);
    cmd(1, 64'h06, 9);
    chk("wel", write_enable_latch, 1'b1);
    cmd(6, {8'h42, 24'h001000, d0, d1}, 9);
    chk("secprog start", {busy, write_enable_latch, kind}, {4'h0, 1'b1, 1'b0, OP_SECPROG});
    wait_busy(200, 1'b0);
    cmd(5, {8'h42, 24'h0013FF, d1}, 9);
    chk("no wel busy", busy, 1'b0);
    cmd(1, 64'h06, 9);
    cmd(5, {8'h42, 24'h001400, d1}, 9);
    chk("bad addr busy", busy, 1'b0);
    cmd(5, {8'h42, 24'h0013FF, d1}, 9);
    chk("last byte busy", busy, 1'b1);
    wait_busy(200, 1'b0);
    exp_q.push_back(d1);
    exp_q.push_back(d0);
    exp_q.push_back(d1);
    cmd(8, {8'h48, 24'h0013FF, 8'h00, 24'h000000}, 5);
    lock = 3'b010;
    cmd(1, 64'h06, 9);
    cmd(5, {8'h42, 24'h002000, d0}, 9);
    chk("locked busy", busy, 1'b0);
    lock = 3'b000;
    cmd(5, {8'h42, 24'h002000, d0}, 9);
    chk("still locked", busy, 1'b0);
    for (int j = 0; j < 2; j++) begin
      cmd(1, 64'h06, 9);
      cmd(hn[j], hop[j], 9);
      chk("kind", kind, j ? OP_PROG : OP_ERASE);
      cmd(1, 64'hB9, 9);
      host.tick(`FSR_DP_CYC + 25);
      chk("sleep busy", {sleep, busy}, 2'b01);
      cmd(1, 64'h75, 9);
      chk("halt", {halt, busy}, j ? 3'b101 : 3'b011);
      wait_busy(600, 1'b0);
      cmd(1, 64'h06, 9);
      cmd(hn[j], hop[j], 9);
      chk("halted refuse", busy, 1'b0);
      if (j == 0) begin
        cmd(6, {8'h42, 24'h003000, d0, d1}, 9);
        chk("nested prog", {halt, busy, kind}, {2'b01, 1'b1, OP_SECPROG});
        wait_busy(200, 1'b0);
      end
      cmd(1, 64'h7A, 9);
      chk("resume", {halt, busy}, 3'b001);
      wait_busy(4000, 1'b0);
    end
    cmd(1, 64'h7A, 9);
    chk("stray resume", {halt, busy}, 3'b000);
    cmd(1, 64'h04, 9);
    chk("wrdi", write_enable_latch, 1'b0);
    cmd(2, 64'hB900, 9);
    host.tick(`FSR_DP_CYC + 5);
    chk("long sleep frame", sleep, 1'b0);
    cmd(1, 64'hB9, 9);
    host.tick(`FSR_DP_CYC + 5);
    chk("asleep", sleep, 1'b1);
    cmd(1, 64'h06, 9);
    chk("asleep wel", write_enable_latch, 1'b0);
    exp_q.push_back(`FSR_DEVICE_ID);
    exp_q.push_back(`FSR_DEVICE_ID);
    cmd(6, 64'hAB0000000000, 4);
    chk("woken", sleep, 1'b0);
    host.tick(`FSR_RES1_CYC);
    cmd(1, 64'h66, 9);
    cmd(1, 64'h06, 9);
    cmd(1, 64'h99, 9);
    chk("broken pair", {rbusy, write_enable_latch}, 2'b01);
    cmd(1, 64'h66, 9);
    cmd(1, 64'h99, 9);
    chk("reset", {rbusy, write_enable_latch, 6'(clr_n)}, 8'h81);
    cmd(1, 64'h06, 9);
    chk("recovery wel", write_enable_latch, 1'b0);
    host.tick(`FSR_RST_CYC);
    chk("recovered", rbusy, 1'b0);
    chk("queue empty", 8'(exp_q.size()), 8'h00);
    wrap_up();
  end
endmodule

// File: dv/fsr_host.sv
// Host serial controller model framing commands to the flash core
`timescale 1ns/10ps
module fsr_host (
  // Clock
  input  wire logic       clk,
  // Serial pins
  output logic            cs_n,
  output logic            sclk,
  output logic            si,
  input  wire logic       so,
  // Bytes received after the header
  output logic            rx_stb,
  output logic [7:0]      rx_byte
);
  logic [7:0] tx [16];

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Whole frame in one select, MSB first, clock idles low
  task automatic xfer(input int n, input int hdr);
    logic [7:0] r;
    tick(1);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        si = tx[i][b];
        tick(4);
        r[b] = so;
        sclk = 1'b1;
        tick(4);
        sclk = 1'b0;
      end
      if (i >= hdr) begin
        rx_byte = r;
        rx_stb = 1'b1;
        tick(1);
        rx_stb = 1'b0;
      end
    end
    tick(4);
    cs_n = 1'b1;
    // Released data line must not keep its last value
    si = ~si;
    tick(8);
  endtask
endmodule
